// [design/flash_self_programming_ctrl.v]
// Flash self-programming sequencer: control register, store and load
// decoding, page buffer, erase and write timing, fuse/lock/signature reads.
// Assumes the CPU gives one-cycle strobes for control writes, store and
// load, and stops while cpu_halt is high. Flash array is outside.
`timescale 1ns/1ps
`default_nettype none
`include "flash_spm_defs.vh"
module flash_self_programming_ctrl #(
  parameter WORD_BITS  = 5,
  parameter PAGE_BITS  = 7,
  parameter PROG_CYCLES = `PROG_CYC
) (
  // Clock and reset
  input  wire                 clk_sys,
  input  wire                 rstn,
  // Fuses and lock straps, 0 means programmed
  input  wire                 self_program_fuse,
  input  wire [7:0]           lock_bits,
  input  wire [7:0]           fuse_low_byte,
  input  wire [7:0]           fuse_high_byte,
  input  wire [7:0]           fuse_extended_byte,
  // EEPROM status
  input  wire                 eeprom_write_busy_flag,
  // Control register port
  input  wire                 ctl_wr,
  input  wire [7:0]           ctl_wdata,
  output reg  [7:0]           program_store_control_reg,
  // Store and load instruction strobes
  input  wire                 program_store_instr,
  input  wire                 load_instr,
  input  wire [15:0]          zptr,
  input  wire [15:0]          data_word_pair,
  // Flash read data for normal loads and signature table byte
  input  wire [15:0]          flash_rd_word,
  input  wire [7:0]           sig_byte,
  output reg  [15:0]          flash_rd_addr,
  output reg  [7:0]           sig_index,
  // Load result
  output reg                  load_valid,
  output reg  [7:0]           load_data,
  // Flash array command side
  output reg                  flash_erase,
  output reg                  flash_write,
  output reg  [PAGE_BITS-1:0] flash_page,
  output reg  [15:0]          flash_wdata,
  output reg  [WORD_BITS-1:0] flash_word,
  // CPU halt
  output reg                  cpu_halt
);
  // ------------------------------------------------------------
  // State codes
  // ------------------------------------------------------------
  localparam ST_IDLE  = 2'd0;  // Waiting for command
  localparam ST_ERASE = 2'd1;  // Erasing page
  localparam ST_WRITE = 2'd2;  // Writing page
  localparam ST_DUMP  = 2'd3;  // Streaming buffer to flash

  reg [1:0]           state_ff;     // Sequencer state
  reg [1:0]           nxt_state;
  reg [2:0]           win_ff;       // Cycles left in store window
  reg [2:0]           nxt_win;
  reg [7:0]           ctl_ff;       // Control bits
  reg [7:0]           nxt_ctl;
  reg [PAGE_BITS-1:0] page_ff;      // Latched page of operation
  reg [WORD_BITS-1:0] dump_ff;      // Word being streamed
  reg [WORD_BITS-1:0] nxt_dump;
  reg                 loading_ff;   // Buffer holds loaded data
  reg                 prog_ok_ff;   // Fuse caught after reset
  reg                 started_ff;   // Reset release seen

  wire                timer_busy;   // Programming time running
  wire [15:0]         buf_rd;       // Buffer word under dump
  wire                buf_wr;       // Word load strobe
  wire                buf_clr;      // Buffer clear strobe
  reg                 timer_go;     // Start of a timed op

  // ------------------------------------------------------------
  // Fuse capture at reset release
  // ------------------------------------------------------------
  // A strap must not feed the async reset value, so catch it clocked
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prog_ok_ff <= 1'b0;
      started_ff <= 1'b0;
    end else if (!started_ff) begin
      started_ff <= 1'b1;
      prog_ok_ff <= ~self_program_fuse;
    end
  end

  // ------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------
  wire win_open  = (win_ff != 3'h0) && ctl_ff[`CTL_STORE_EN];
  wire store_hit = program_store_instr && win_open && (state_ff == ST_IDLE)
                   && prog_ok_ff && !eeprom_write_busy_flag;
  wire cmd_erase = store_hit && (ctl_ff == `CMD_ERASE);
  wire cmd_write = store_hit && (ctl_ff == `CMD_WRITE);
  wire cmd_load  = store_hit && (ctl_ff == `CMD_LOAD);
  wire rd_fuse   = load_instr && win_open && (win_ff != `STORE_WIN_CYC - 3'h3)
                   && ctl_ff[`CTL_FUSE_READ] && !eeprom_write_busy_flag;
  wire rd_sig    = load_instr && win_open && (win_ff != `STORE_WIN_CYC - 3'h3)
                   && ctl_ff[`CTL_SIG_READ];
  // Clear-bit write or EEPROM write in the middle of loading loses the data
  wire clr_write = ctl_wr && ctl_wdata[`CTL_CLEAR_BUF] && ctl_wdata[`CTL_STORE_EN];
  wire eep_kill  = loading_ff && eeprom_write_busy_flag;

  assign buf_wr  = cmd_load;
  // The dump hands over to the timed write; the last word is captured on that same edge
  assign buf_clr = clr_write || eep_kill || (state_ff == ST_DUMP && nxt_state == ST_WRITE);

  // ------------------------------------------------------------
  // Control register and window, next values
  // ------------------------------------------------------------
  always @* begin
    nxt_ctl   = ctl_ff;
    nxt_win   = win_ff;
    nxt_state = state_ff;
    nxt_dump  = dump_ff;
    timer_go  = 1'b0;
    // Window countdown; bits self-clear when it runs out
    if (win_ff != 3'h0 && state_ff == ST_IDLE) begin
      nxt_win = win_ff - 3'h1;
      if (win_ff == 3'h1) begin
        nxt_ctl = 8'h00;
      end
    end
    case (state_ff)
      ST_IDLE: begin
        if (cmd_erase) begin
          nxt_state = ST_ERASE;
          timer_go  = 1'b1;
        end else if (cmd_write) begin
          nxt_state = ST_DUMP;
          nxt_dump  = {WORD_BITS{1'b0}};
        end else if (store_hit || rd_fuse || rd_sig) begin
          nxt_ctl = 8'h00;
          nxt_win = 3'h0;
        end else if (ctl_wr && !eeprom_write_busy_flag) begin
          // A write with the enable bit set reopens the window; without it the window closes
          nxt_ctl = ctl_wdata & `CTL_WR_MASK;
          nxt_win = ctl_wdata[`CTL_STORE_EN] ? `STORE_WIN_CYC : 3'h0;
          if (ctl_wdata[`CTL_CLEAR_BUF]) begin
            nxt_ctl[`CTL_CLEAR_BUF] = 1'b0;
          end
        end
      end
      ST_DUMP: begin
        // Copy each buffer word into the array before the timed write
        nxt_dump = dump_ff + {{(WORD_BITS-1){1'b0}}, 1'b1};
        if (dump_ff == {WORD_BITS{1'b1}}) begin
          nxt_state = ST_WRITE;
          timer_go  = 1'b1;
        end
      end
      ST_ERASE, ST_WRITE: begin
        // Enable bit stays high until the operation finishes, unless the store came in the last window cycle
        if (!timer_busy && !timer_go) begin
          nxt_state = ST_IDLE;
          nxt_ctl   = 8'h00;
          nxt_win   = 3'h0;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Sequencer registers
  // ------------------------------------------------------------
  // Reset does not reach the timer, but it still sends the sequencer to idle and drops the halt, so a write in flight is cut short
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_ff   <= ST_IDLE;
      win_ff     <= 3'h0;
      ctl_ff     <= 8'h00;
      dump_ff    <= {WORD_BITS{1'b0}};
      page_ff    <= {PAGE_BITS{1'b0}};
      loading_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      win_ff   <= nxt_win;
      ctl_ff   <= nxt_ctl;
      dump_ff  <= nxt_dump;
      if (cmd_erase || cmd_write) begin
        page_ff <= zptr[WORD_BITS+PAGE_BITS:WORD_BITS+1];
      end
      if (buf_clr) begin
        loading_ff <= 1'b0;
      end else if (cmd_load) begin
        loading_ff <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Outputs to CPU and flash array
  // ------------------------------------------------------------
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      program_store_control_reg <= 8'h00;
      cpu_halt    <= 1'b0;
      flash_erase <= 1'b0;
      flash_write <= 1'b0;
      flash_page  <= {PAGE_BITS{1'b0}};
      flash_wdata <= 16'h0000;
      flash_word  <= {WORD_BITS{1'b0}};
    end else begin
      program_store_control_reg <= nxt_ctl;
      // Halt from the store until the array finishes
      cpu_halt    <= (nxt_state != ST_IDLE);
      flash_erase <= (nxt_state == ST_ERASE);
      flash_write <= (state_ff == ST_DUMP);
      flash_page  <= (cmd_erase || cmd_write) ? zptr[WORD_BITS+PAGE_BITS:WORD_BITS+1] : page_ff;
      flash_wdata <= buf_rd;
      flash_word  <= dump_ff;
    end
  end

  // ------------------------------------------------------------
  // Load instruction result
  // ------------------------------------------------------------
  // Returns one cycle after the load; normal loads pick the byte by bit 0
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      load_valid    <= 1'b0;
      load_data     <= 8'h00;
      flash_rd_addr <= 16'h0000;
      sig_index     <= 8'h00;
    end else begin
      load_valid    <= load_instr;
      flash_rd_addr <= {1'b0, zptr[15:1]};
      sig_index     <= zptr[7:0];
      if (rd_fuse) begin
        // Straps already carry 0 for programmed, passed as they are
        case (zptr)
          `PTR_LOCK:      load_data <= lock_bits;
          `PTR_FUSE_LOW:  load_data <= fuse_low_byte;
          `PTR_FUSE_HIGH: load_data <= fuse_high_byte;
          `PTR_FUSE_EXT:  load_data <= fuse_extended_byte;
          default:        load_data <= 8'hff;
        endcase
      end else if (rd_sig) begin
        load_data <= sig_byte;
      end else if (load_instr) begin
        load_data <= zptr[0] ? flash_rd_word[15:8] : flash_rd_word[7:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Sub-blocks
  // ------------------------------------------------------------
  page_buffer #(
    .WORD_BITS (WORD_BITS)
  ) u_buf (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .wr_en   (buf_wr),
    .wr_word (zptr[WORD_BITS:1]),
    .wr_data (data_word_pair),
    .clr     (buf_clr),
    .rd_word (dump_ff),
    .rd_data (buf_rd)
  );

  prog_timer #(
    .CYCLES (PROG_CYCLES)
  ) u_tmr (
    .clk_sys (clk_sys),
    .rstn    (1'b1),
    .start   (timer_go),
    .busy    (timer_busy)
  );
endmodule
`default_nettype wire

// [design/flash_spm_defs.vh]
// Constants for the flash self-programming controller.
// Assumes inclusion by bare name from the design files.
//
// Contract
// - Store disabled unless fuse programmed zero
// - Buffer loads one word per store
// - Buffer words writable in any order
// - Control 00000011 plus store erases page
// - CPU halted during whole page erase
// - Control 00000001 plus store loads word
// - Buffer cleared after write, clear bit, reset
// - EEPROM write during loading discards buffer
// - Control 00000101 plus store writes page
// - CPU halted during whole page write
// - Low address bits word, high bits page
// - Load addresses bytes using pointer bit zero
// - EEPROM busy blocks programming and fuse reads
// - Programmed fuse bits read zero, else one
// - Fuse-lock read at pointer 1 returns lock
// - Read enables self-clear after read or timeout
// - Pointers 0,3,2 return fuse low, high, extended
// - Signature read returns table entry by pointer
// - Enable bit lasts four cycles, held during ops; a store in the fourth cycle clears it at once
// - Erase and write last 3.7 to 4.5 ms
// - Write started before reset still completes; here reset idles the sequencer and clears the buffer, only the timer runs on
`ifndef FLASH_SPM_DEFS_VH
`define FLASH_SPM_DEFS_VH

// ------------------------------------------------------------
// Control register bit positions
// ------------------------------------------------------------
`define CTL_STORE_EN   0
`define CTL_PAGE_ERASE 1
`define CTL_PAGE_WRITE 2
`define CTL_FUSE_READ  3
`define CTL_CLEAR_BUF  4
`define CTL_SIG_READ   5
`define CTL_WR_MASK    8'h3f

// ------------------------------------------------------------
// Command codes written to the control register
// ------------------------------------------------------------
`define CMD_ERASE      8'h03
`define CMD_LOAD       8'h01
`define CMD_WRITE      8'h05

// ------------------------------------------------------------
// Fuse and lock read pointer values
// ------------------------------------------------------------
`define PTR_FUSE_LOW   16'h0000
`define PTR_LOCK       16'h0001
`define PTR_FUSE_EXT   16'h0002
`define PTR_FUSE_HIGH  16'h0003

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define STORE_WIN_CYC  3'h4
`define LOAD_WIN_CYC   3'h3
`define CLK_HZ         40000000
`define PROG_MIN_US    3700
`define PROG_MAX_US    4500
// Aim at the middle of the window, rounded down to whole cycles
`define PROG_CYC       ((`CLK_HZ / 1000000) * ((`PROG_MIN_US + `PROG_MAX_US) / 2))

`endif

// [design/page_buffer.v]
// Temporary page buffer: one word per entry, each with a valid flag.
// Assumes a single clock and that writes and clears never collide badly;
// a clear wins over a write in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module page_buffer #(
  parameter WORD_BITS = 5
) (
  // Clock and reset
  input  wire                 clk_sys,
  input  wire                 rstn,
  // Write side
  input  wire                 wr_en,
  input  wire [WORD_BITS-1:0] wr_word,
  input  wire [15:0]          wr_data,
  input  wire                 clr,
  // Read side
  input  wire [WORD_BITS-1:0] rd_word,
  output wire [15:0]          rd_data
);
  localparam DEPTH = 1 << WORD_BITS;

  reg [15:0]      mem_ff [0:DEPTH-1];  // Word storage
  reg [DEPTH-1:0] vld_ff;              // Loaded flags

  // ------------------------------------------------------------
  // Storage, any order of addresses
  // ------------------------------------------------------------
  // Erased flash reads all ones, so an unloaded word reads ones too
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_ent
      always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          vld_ff[gi]  <= 1'b0;
          mem_ff[gi]  <= 16'hffff;
        end else if (clr) begin
          vld_ff[gi]  <= 1'b0;
          mem_ff[gi]  <= 16'hffff;
        end else if (wr_en && wr_word == gi) begin
          vld_ff[gi]  <= 1'b1;
          mem_ff[gi]  <= wr_data;
        end
      end
    end
  endgenerate

  assign rd_data = vld_ff[rd_word] ? mem_ff[rd_word] : 16'hffff;
endmodule
`default_nettype wire

// [design/prog_timer.v]
// Programming duration timer for erase and write operations.
// Assumes start is a one-cycle pulse while not busy.
`timescale 1ns/1ps
`default_nettype none
module prog_timer #(
  parameter CYCLES = 32'd164000
) (
  // Clock and reset
  input  wire clk_sys,
  input  wire rstn,
  // Control
  input  wire start,
  output wire busy
);
  reg [31:0] cnt_ff;  // Cycles left

  // ------------------------------------------------------------
  // Down counter
  // ------------------------------------------------------------
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= 32'h0;
    end else if (start) begin
      cnt_ff <= CYCLES;
    end else if (cnt_ff != 32'h0) begin
      cnt_ff <= cnt_ff - 32'h1;
    end
  end

  assign busy = (cnt_ff != 32'h0);
endmodule
`default_nettype wire

// [verif/flash_array_model.sv]
// Flash array and signature table behind the sequencer.
// Assumes the array reads combinationally from the registered address.
`timescale 1ns/1ps
`default_nettype none
module flash_array_model #(
  parameter WORD_BITS = 2,
  parameter PAGE_BITS = 3
) (
  // Clock
  input  wire logic                 clk_sys,
  // Read side
  input  wire logic [15:0]          flash_rd_addr,
  output wire logic [15:0]          flash_rd_word,
  input  wire logic [7:0]           sig_index,
  output wire logic [7:0]           sig_byte,
  // Program side
  input  wire logic                 flash_erase,
  input  wire logic                 flash_write,
  input  wire logic [PAGE_BITS-1:0] flash_page,
  input  wire logic [WORD_BITS-1:0] flash_word,
  input  wire logic [15:0]          flash_wdata
);
  localparam N = 1 << (WORD_BITS + PAGE_BITS);
  logic [15:0] mem [0:N-1];  // Array contents, a known pattern at start
  initial for (int i = 0; i < N; i++) mem[i] = 16'ha500 | 16'(i);
  // Erase sets a page; programming only clears bits, so an unerased page corrupts
  always @(posedge clk_sys) begin
    for (int w = 0; w < (1 << WORD_BITS); w++)
      if (flash_erase) mem[{flash_page, WORD_BITS'(w)}] <= 16'hffff;
    if (flash_write) mem[{flash_page, flash_word}] <= mem[{flash_page, flash_word}] & flash_wdata;
  end
  assign flash_rd_word = mem[flash_rd_addr[WORD_BITS+PAGE_BITS-1:0]];
  assign sig_byte = sig_index ^ 8'h5a;  // Arbitrary table contents
endmodule
`default_nettype wire

// [verif/flash_self_programming_ctrl_assertions.sv]
// Concurrent checks on the self-programming sequencer ports.
// Assumes one clock, resets only while idle, PROG_CYCLES of 8 or more.
`timescale 1ns/1ps
`default_nettype none
module flash_spm_checker #(
  parameter WORD_BITS   = 5,
  parameter PAGE_BITS   = 7,
  parameter PROG_CYCLES = 20
) (
  // Clock and reset
  input wire logic                 clk_sys,
  input wire logic                 rstn,
  // Straps and status
  input wire logic                 self_program_fuse,
  input wire logic [7:0]           lock_bits,
  input wire logic                 eeprom_write_busy_flag,
  // CPU side
  input wire logic                 ctl_wr,
  input wire logic [7:0]           ctl_wdata,
  input wire logic [7:0]           program_store_control_reg,
  input wire logic                 program_store_instr,
  input wire logic                 load_instr,
  input wire logic [15:0]          zptr,
  input wire logic                 load_valid,
  input wire logic [7:0]           load_data,
  // Flash side
  input wire logic                 flash_erase,
  input wire logic                 flash_write,
  input wire logic [PAGE_BITS-1:0] flash_page,
  input wire logic                 cpu_halt
);
  // Page field of the pointer
  wire [PAGE_BITS-1:0] zpage = zptr[WORD_BITS+PAGE_BITS:WORD_BITS+1];
  // A control write that the block takes
  wire                 ok_ctl = ctl_wr && !eeprom_write_busy_flag && !cpu_halt;
  // Length of the running halt; dump cycles and slack come on top of the timer
  reg  [31:0]          halt_cnt_ff;
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      halt_cnt_ff <= 32'h0;
    else if (cpu_halt)
      halt_cnt_ff <= halt_cnt_ff + 32'h1;
    else
      halt_cnt_ff <= 32'h0;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_erase_start: assert property (ok_ctl && ctl_wdata == 8'h03 && !self_program_fuse ##1
    program_store_instr && !eeprom_write_busy_flag |=> cpu_halt && flash_erase && flash_page == $past(zpage))
    else $error("erase did not start on the addressed page");
  a_unfused_idle: assert property (self_program_fuse && program_store_instr && !cpu_halt |=> !cpu_halt)
    else $error("store acted with the fuse unprogrammed");
  a_busy_blocks: assert property (eeprom_write_busy_flag && program_store_instr && !cpu_halt |=> !cpu_halt)
    else $error("store acted during an eeprom write");
  a_window_shut: assert property (ok_ctl && ctl_wdata == 8'h03 ##1
    (!program_store_instr && !ctl_wr)[*5] ##1 program_store_instr |=> !cpu_halt)
    else $error("late store still started an erase");
  a_load_answer: assert property (load_valid == $past(load_instr))
    else $error("load answer not one cycle after the load");
  a_lock_read: assert property (ok_ctl && ctl_wdata == 8'h09 ##1 load_instr && zptr == 16'h0001
    |=> load_data == $past(lock_bits))
    else $error("lock read returned a wrong byte");
  a_halt_held: assert property ($rose(cpu_halt) |-> cpu_halt[*8])
    else $error("halt dropped early");
  a_halt_bound: assert property (halt_cnt_ff <= PROG_CYCLES + (1 << WORD_BITS) + 4)
    else $error("halt lasted too long");
  a_reg_cleared: assert property ($fell(cpu_halt) |-> ##[0:1] program_store_control_reg == 8'h00)
    else $error("control bits not cleared after the operation");
  a_write_halted: assert property (flash_write |-> cpu_halt)
    else $error("flash written while the cpu runs");

  c_erase: cover property ($rose(flash_erase));
  c_write: cover property ($rose(flash_write));
  c_lock: cover property (ok_ctl && ctl_wdata == 8'h09 ##1 load_instr);
endmodule

bind flash_self_programming_ctrl flash_spm_checker #(.WORD_BITS(WORD_BITS), .PAGE_BITS(PAGE_BITS),
  .PROG_CYCLES(PROG_CYCLES)) u_chk (.clk_sys(clk_sys), .rstn(rstn), .self_program_fuse(self_program_fuse),
  .lock_bits(lock_bits), .eeprom_write_busy_flag(eeprom_write_busy_flag), .ctl_wr(ctl_wr),
  .ctl_wdata(ctl_wdata), .program_store_control_reg(program_store_control_reg),
  .program_store_instr(program_store_instr), .load_instr(load_instr), .zptr(zptr), .load_valid(load_valid),
  .load_data(load_data), .flash_erase(flash_erase), .flash_write(flash_write), .flash_page(flash_page),
  .cpu_halt(cpu_halt));
`default_nettype wire

// [verif/flash_self_programming_ctrl_bench.sv]
// Self-checking bench: CPU-side tasks for control writes, stores, loads.
// Assumes a short programming time and a small page geometry.
`timescale 1ns/1ps
`default_nettype none
module flash_self_programming_ctrl_bench;
  localparam WB = 2;
  localparam PB = 3;
  localparam PC = 20;
  localparam logic [7:0] STRAP [4] = '{8'h62, 8'hfc, 8'hfe, 8'hdf};  // Fuse low, lock, ext, high
  logic clk_sys = 1'b0, rstn = 1'b0, self_program_fuse = 1'b0, eeprom_write_busy_flag = 1'b0;
  logic ctl_wr = 1'b0, program_store_instr = 1'b0, load_instr = 1'b0;
  logic [7:0] ctl_wdata = 8'h00;
  logic [15:0] zptr = 16'h0, data_word_pair = 16'h0;
  wire [7:0] program_store_control_reg, sig_index, load_data, sig_byte;
  wire [15:0] flash_rd_addr, flash_wdata, flash_rd_word;
  wire load_valid, flash_erase, flash_write, cpu_halt;
  wire [PB-1:0] flash_page;
  wire [WB-1:0] flash_word;
  int miscompares = 0, check_count = 0, cycles = 0;

  always #12.5 clk_sys = ~clk_sys;

  flash_self_programming_ctrl #(.WORD_BITS(WB), .PAGE_BITS(PB), .PROG_CYCLES(PC)) i_dut (
    .clk_sys(clk_sys), .rstn(rstn), .self_program_fuse(self_program_fuse), .lock_bits(STRAP[1]),
    .fuse_low_byte(STRAP[0]), .fuse_high_byte(STRAP[3]), .fuse_extended_byte(STRAP[2]),
    .eeprom_write_busy_flag(eeprom_write_busy_flag), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata),
    .program_store_control_reg(program_store_control_reg), .program_store_instr(program_store_instr),
    .load_instr(load_instr), .zptr(zptr), .data_word_pair(data_word_pair), .flash_rd_word(flash_rd_word),
    .sig_byte(sig_byte), .flash_rd_addr(flash_rd_addr), .sig_index(sig_index), .load_valid(load_valid),
    .load_data(load_data), .flash_erase(flash_erase), .flash_write(flash_write), .flash_page(flash_page),
    .flash_wdata(flash_wdata), .flash_word(flash_word), .cpu_halt(cpu_halt));

  flash_array_model #(.WORD_BITS(WB), .PAGE_BITS(PB)) i_flash (.clk_sys(clk_sys),
    .flash_rd_addr(flash_rd_addr), .flash_rd_word(flash_rd_word), .sig_index(sig_index), .sig_byte(sig_byte),
    .flash_erase(flash_erase), .flash_write(flash_write), .flash_page(flash_page), .flash_word(flash_word),
    .flash_wdata(flash_wdata));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Control write; entered and left just after a rising edge
  task automatic ctl(input logic [7:0] v);
    ctl_wr <= 1'b1;
    ctl_wdata <= v;
    @(posedge clk_sys);
    ctl_wr <= 1'b0;
  endtask

  // Control write, store after gap cycles, then wait out any halt
  task automatic cmd(input logic [7:0] v, input logic [15:0] z, input logic [15:0] d, input int gap,
                     input logic eh);
    ctl(v);
    repeat (gap) @(posedge clk_sys);
    program_store_instr <= 1'b1;
    zptr <= z;
    data_word_pair <= d;
    @(posedge clk_sys);
    program_store_instr <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk("cpu_halt", {15'h0, eh}, {15'h0, cpu_halt});
    for (int i = 0; i < 200 && cpu_halt === 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk("halt release", 16'h0, {15'h0, cpu_halt});
    @(posedge clk_sys);
  endtask

  // Load byte z, optionally behind a control write and a gap
  task automatic rd(input logic [7:0] v, input logic [15:0] z, input int gap, input logic [7:0] exp);
    zptr <= z;
    @(posedge clk_sys);
    if (v != 8'h00) ctl(v);
    repeat (gap) @(posedge clk_sys);
    load_instr <= 1'b1;
    @(posedge clk_sys);
    load_instr <= 1'b0;
    #1;
    chk("load_valid", 16'h1, {15'h0, load_valid});
    chk("load_data", {8'h0, exp}, {8'h0, load_data});
    @(posedge clk_sys);
  endtask

  // Read back a whole page byte by byte, high byte on odd pointers
  task automatic page_chk(input int p, input logic [15:0] w0, w1, w2, w3);
    logic [15:0] w [4];
    w = '{w0, w1, w2, w3};
    for (int i = 0; i < 8; i++) rd(8'h00, 16'(p * 8 + i), 0, w[i/2][8*(i%2) +: 8]);
  endtask

  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      tally_and_finish;
    end
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    for (int i = 0; i < 4; i++) rd(8'h09, 16'(i), 0, STRAP[i]);
    rd(8'h21, 16'h0005, 0, 8'h5f);
    rd(8'h09, 16'h0001, 4, 8'ha5);
    chk("control reg", 16'h0, {8'h0, program_store_control_reg});
    rd(8'h00, 16'h0012, 0, 8'h09);
    // Erase, load out of order, write the same page
    cmd(8'h03, 16'h0028, 16'h0, 0, 1'b1);
    cmd(8'h01, 16'h002d, 16'h1234, 0, 1'b0);
    cmd(8'h01, 16'h0028, 16'habcd, 0, 1'b0);
    cmd(8'h05, 16'h0028, 16'h0, 0, 1'b1);
    page_chk(5, 16'habcd, 16'hffff, 16'h1234, 16'hffff);
    // Buffer empty after a write
    cmd(8'h03, 16'h0030, 16'h0, 0, 1'b1);
    cmd(8'h05, 16'h0030, 16'h0, 0, 1'b1);
    page_chk(6, 16'hffff, 16'hffff, 16'hffff, 16'hffff);
    // Clear bit drops a loaded word
    cmd(8'h01, 16'h003a, 16'h5555, 0, 1'b0);
    ctl(8'h11);
    @(posedge clk_sys);
    cmd(8'h03, 16'h0038, 16'h0, 0, 1'b1);
    cmd(8'h05, 16'h0038, 16'h0, 0, 1'b1);
    page_chk(7, 16'hffff, 16'hffff, 16'hffff, 16'hffff);
    // An eeprom write drops loaded words and blocks programming
    cmd(8'h01, 16'h0016, 16'h0f0f, 0, 1'b0);
    eeprom_write_busy_flag <= 1'b1;
    cmd(8'h03, 16'h0010, 16'h0, 0, 1'b0);
    eeprom_write_busy_flag <= 1'b0;
    @(posedge clk_sys);
    cmd(8'h03, 16'h0010, 16'h0, 0, 1'b1);
    cmd(8'h05, 16'h0010, 16'h0, 0, 1'b1);
    page_chk(2, 16'hffff, 16'hffff, 16'hffff, 16'hffff);
    // Store too late after the control write
    cmd(8'h03, 16'h0008, 16'h0, 5, 1'b0);
    // Unprogrammed fuse: a store changes nothing
    rstn <= 1'b0;
    self_program_fuse <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    cmd(8'h03, 16'h0018, 16'h0, 0, 1'b0);
    page_chk(3, 16'ha50c, 16'ha50d, 16'ha50e, 16'ha50f);
    tally_and_finish;
  end
endmodule
`default_nettype wire
